// ### include/fwp_pkg.sv
/*
 * shared constants of the serial flash protection block: opcodes, status
 * and lock byte layout, reset values and self-timed cycle lengths.
 * assumes a 50 MHz system clock on both ends of the link.
 */
package fwp_pkg;
    // instruction codes
    localparam logic [7:0] OP_WRITE_ENABLE    = 8'h06;
    localparam logic [7:0] OP_STATUS_READ     = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE    = 8'h01;
    localparam logic [7:0] OP_LOCK_READ       = 8'he8;
    localparam logic [7:0] OP_LOCK_WRITE      = 8'he5;
    localparam logic [7:0] OP_PE_SUSPEND      = 8'h75;
    localparam logic [7:0] OP_PE_RESUME       = 8'h7a;
    localparam logic [7:0] OP_PAGE_PROGRAM    = 8'h02;
    localparam logic [7:0] OP_SUBSECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_SECTOR_ERASE    = 8'hd8;
    localparam logic [7:0] OP_BULK_ERASE      = 8'hc7;
    // status byte layout
    localparam int SR_WIP_BIT  = 0;
    localparam int SR_WEL_BIT  = 1;
    localparam int SR_BP_LSB   = 2;
    localparam int SR_TB_BIT   = 5;
    localparam int SR_BP3_BIT  = 6;
    localparam int SR_STATUS_WRITE_DISABLE_BIT = 7;
    localparam logic [5:0] SR_HI_RESET = 6'h00;
    // sector lock byte layout
    localparam int LK_WRITE_LOCK_BIT = 0;
    localparam int LK_DOWN_BIT       = 1;
    localparam logic LK_RESET        = 1'b0;
    // frame lengths in serial bits
    localparam int OPCODE_BITS = 8;
    localparam int ADDR_BITS   = 24;
    localparam int DATA_BITS   = 8;
    localparam int SECTOR_LSB  = 16;
    // self-timed cycles
    localparam int CLK_PERIOD_NS        = 20;
    localparam int STATUS_WRITE_TIME_NS = 2000;
    localparam int PROGRAM_TIME_NS      = 8000;
    localparam int ERASE_TIME_NS        = 40000;
    localparam int STATUS_WRITE_CYCLES  =
        (STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROGRAM_CYCLES       =
        (PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERASE_CYCLES         =
        (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // host serial clock half period in system clocks
    localparam int SCLK_HALF_CYCLES = 10;

    typedef enum logic [1:0] {
        JOB_STATUS  = 2'h0,
        JOB_PROGRAM = 2'h1,
        JOB_ERASE   = 2'h2
    } fwp_job_type;
endpackage

// ### include/fwp_spi_if.sv
/*
 * single-bit serial link between the host controller and the flash.
 * assumes a pull-up on the data output line while the flash lets it go.
 */
`timescale 1ns/1ns
interface fwp_spi_if;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic wp_n;
    logic miso;
    logic miso_oe_n;
    logic miso_line;

    assign miso_line = miso_oe_n ? 1'b1 : miso;

    modport dev (input cs_n, sclk, mosi, wp_n, output miso, miso_oe_n);
    modport host (output cs_n, sclk, mosi, wp_n, input miso_line);
endinterface

// ### rtl/fwp_pin_sync.sv
/*
 * three-stage synchroniser with change qualification and edge pulses.
 * assumes inputs are asynchronous pins; a change counts once the second
 * and third stages agree.
 */
`timescale 1ns/1ns
module fwp_pin_sync #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT  = '0
) (
    // clock and reset
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst,
    // pins and qualified results
    input  wire logic [WIDTH-1:0] i_pin,
    output logic      [WIDTH-1:0] o_level,
    output logic      [WIDTH-1:0] o_rise,
    output logic      [WIDTH-1:0] o_fall
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] agree;

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            s1_r    <= INIT;
            s2_r    <= INIT;
            s3_r    <= INIT;
            o_level <= INIT;
        end
        else
        begin
            s1_r    <= i_pin;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            o_level <= (agree & s3_r) | (~agree & o_level);
        end
    end

    assign agree  = ~(s2_r ^ s3_r);
    assign o_rise = agree & s3_r & ~o_level;
    assign o_fall = agree & ~s3_r & o_level;
endmodule // fwp_pin_sync

// ### rtl/fwp_flash_dev.sv
/*
 * flash end of the link: status register, write enable latch, hardware
 * and software protection, per-sector volatile lock bits, and a timed
 * program/erase engine with one level of nested suspend.
 * assumes mode 0 framing: bits taken on clock rise, data out on fall.
 *
// Overview of operation
// RULE_01 - resume ignored unless something is suspended
// RULE_02 - resume sets busy and clears ready
// RULE_03 - resume restarts most recently suspended job first
// RULE_04 - status read always allowed, byte repeats
// RULE_05 - host polls busy before next instruction
// RULE_06 - status write needs write enable latch
// RULE_07 - status write ends exactly after data byte
// RULE_08 - status write keeps latch and busy bits
// RULE_09 - status write runs timed cycle, then clears latch
// RULE_10 - status write updates protect, top/bottom, disable bits
// RULE_11 - disable bit low: pin level ignored
// RULE_12 - disable bit high: pin low rejects write
// RULE_13 - hardware protection: disable high, pin low
// RULE_14 - protected region rejects program and erase
// RULE_15 - lock read: opcode, address, then byte out
// RULE_16 - chip select high ends lock read output
// RULE_17 - lock read rejected while cycle runs
// RULE_18 - lock byte: lock-down bit 1, write-lock 0
// RULE_19 - lock-down freezes sector until power-up
// RULE_20 - lock write: latch, opcode, address, data
// RULE_21 - lock write immediate, latch clears at once
// RULE_22 - lock write rejected while cycle runs
// RULE_23 - status: busy bit 0, latch bit 1
 */
`timescale 1ns/1ns
module fwp_flash_dev #(
    parameter int NUM_SECTORS = 256,
    parameter int SR_CYCLES   = fwp_pkg::STATUS_WRITE_CYCLES,
    parameter int PGM_CYCLES  = fwp_pkg::PROGRAM_CYCLES,
    parameter int ERS_CYCLES  = fwp_pkg::ERASE_CYCLES
) (
    // clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    // serial link
    fwp_spi_if.dev    spi,
    // state for the user
    output logic [7:0] o_status,
    output logic       o_pe_ready,
    output logic       o_hw_protected,
    output logic [1:0] o_suspend_depth
);
    if (NUM_SECTORS < 1 || NUM_SECTORS > 256)
        $error("NUM_SECTORS must lie in 1..256");
    if (SR_CYCLES < 2 || PGM_CYCLES < 2 || ERS_CYCLES < 2 ||
        SR_CYCLES > 65535 || PGM_CYCLES > 65535 || ERS_CYCLES > 65535)
        $error("cycle counts must lie in 2..65535");

    // order of sync bits: wp_n, mosi, sclk, cs_n
    logic [3:0]  lvl;
    logic [3:0]  rise;
    logic [3:0]  fall;
    logic [11:0] bitcnt_r;
    logic [31:0] sh_r;
    logic [7:0]  opcode_r;
    logic [23:0] addr_r;
    logic        rd_reject_r;
    logic [5:0]  sr_hi_r;
    logic        wel_r;
    logic        busy_r;
    fwp_pkg::fwp_job_type job_r;
    fwp_pkg::fwp_job_type stk_job_r [2];
    logic [15:0] cnt_r;
    logic [15:0] stk_cnt_r [2];
    logic [1:0]  depth_r;
    logic [NUM_SECTORS-1:0] wlock_r;
    logic [NUM_SECTORS-1:0] ldown_r;

    logic        cs_rise;
    logic        sclk_rise;
    logic        sclk_fall;
    logic [3:0]  bp;
    logic [7:0]  sec;
    logic        sec_ok;
    logic        can_write;
    logic        region_ok;
    logic        write_enable_cmd_go;
    logic        status_write_cmd_go;
    logic        lock_write_cmd_go;
    logic        prog_go;
    logic        erase_go;
    logic        bulk_go;
    logic        suspend_go;
    logic        resume_go;
    logic        done;
    logic        rd_sr;
    logic        rd_lk;
    logic [7:0]  lock_byte;

    function automatic logic sec_protected(input logic [7:0] s,
                                           input logic [3:0] b,
                                           input logic       tb);
        int n;
        n = (b == 4'h0) ? 0 : (1 << (int'(b) - 1));
        if (n > NUM_SECTORS)
            n = NUM_SECTORS;
        return tb ? (int'(s) < n) : (int'(s) >= NUM_SECTORS - n);
    endfunction

    fwp_pin_sync #(
        .WIDTH (4),
        .INIT  (4'h9)
    ) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_pin     ({spi.wp_n, spi.mosi, spi.sclk, spi.cs_n}),
        .o_level   (lvl),
        .o_rise    (rise),
        .o_fall    (fall)
    );

    assign cs_rise   = rise[0];
    assign sclk_rise = rise[1] & ~lvl[0];
    assign sclk_fall = fall[1] & ~lvl[0];

    // frame capture: bits counted on clock rise while selected
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst || lvl[0])
        begin
            bitcnt_r    <= 12'h000;
            sh_r        <= 32'h0000_0000;
            opcode_r    <= 8'h00;
            addr_r      <= 24'h00_0000;
            rd_reject_r <= 1'b0;
        end
        else if (sclk_rise)
        begin
            sh_r <= {sh_r[30:0], lvl[2]};
            if (bitcnt_r != 12'hfff)
                bitcnt_r <= bitcnt_r + 12'h001;
            if (bitcnt_r == 12'(fwp_pkg::OPCODE_BITS - 1))
            begin
                opcode_r    <= {sh_r[6:0], lvl[2]};
                rd_reject_r <= busy_r; // RULE_17
            end
            if (bitcnt_r ==
                12'(fwp_pkg::OPCODE_BITS + fwp_pkg::ADDR_BITS - 1))
                addr_r <= {sh_r[22:0], lvl[2]}; // RULE_15
        end
    end

    // decode of a finished frame on chip select rise
    assign bp = {sr_hi_r[fwp_pkg::SR_BP3_BIT - fwp_pkg::SR_BP_LSB],
                 sr_hi_r[2:0]};
    assign o_hw_protected = sr_hi_r[fwp_pkg::SR_STATUS_WRITE_DISABLE_BIT - 2] &
                            ~lvl[3]; // RULE_13
    assign sec    = addr_r[fwp_pkg::SECTOR_LSB +: 8];
    assign sec_ok = int'(sec) < NUM_SECTORS;
    assign can_write = wel_r & ~busy_r; // RULE_22
    assign region_ok = sec_ok && !wlock_r[sec] &&
        !sec_protected(sec, bp, sr_hi_r[fwp_pkg::SR_TB_BIT - 2]); // RULE_14

    assign write_enable_cmd_go = cs_rise && opcode_r == fwp_pkg::OP_WRITE_ENABLE &&
                     bitcnt_r == 12'(fwp_pkg::OPCODE_BITS);
    assign status_write_cmd_go = cs_rise && opcode_r == fwp_pkg::OP_STATUS_WRITE &&
                     bitcnt_r == 12'(fwp_pkg::OPCODE_BITS +
                                     fwp_pkg::DATA_BITS) && // RULE_07
                     can_write && depth_r == 2'h0 && // RULE_06
                     !o_hw_protected; // RULE_11 RULE_12
    assign lock_write_cmd_go = cs_rise && opcode_r == fwp_pkg::OP_LOCK_WRITE &&
                     bitcnt_r == 12'(fwp_pkg::OPCODE_BITS +
                         fwp_pkg::ADDR_BITS + fwp_pkg::DATA_BITS) &&
                     can_write && depth_r == 2'h0 && sec_ok; // RULE_20 RULE_22
    assign prog_go = cs_rise && opcode_r == fwp_pkg::OP_PAGE_PROGRAM &&
                     bitcnt_r >= 12'(fwp_pkg::OPCODE_BITS +
                         fwp_pkg::ADDR_BITS + fwp_pkg::DATA_BITS) &&
                     bitcnt_r[2:0] == 3'h0 && can_write && region_ok &&
                     (depth_r == 2'h0 || (depth_r == 2'h1 &&
                      stk_job_r[0] == fwp_pkg::JOB_ERASE));
    assign erase_go = cs_rise &&
                     (opcode_r == fwp_pkg::OP_SUBSECTOR_ERASE ||
                      opcode_r == fwp_pkg::OP_SECTOR_ERASE) &&
                     bitcnt_r == 12'(fwp_pkg::OPCODE_BITS +
                                     fwp_pkg::ADDR_BITS) &&
                     can_write && region_ok && depth_r == 2'h0;
    assign bulk_go = cs_rise && opcode_r == fwp_pkg::OP_BULK_ERASE &&
                     bitcnt_r == 12'(fwp_pkg::OPCODE_BITS) &&
                     can_write && depth_r == 2'h0 && bp == 4'h0 &&
                     wlock_r == '0; // RULE_14
    assign suspend_go = cs_rise && opcode_r == fwp_pkg::OP_PE_SUSPEND &&
                     bitcnt_r == 12'(fwp_pkg::OPCODE_BITS) && busy_r &&
                     job_r != fwp_pkg::JOB_STATUS && depth_r != 2'h2;
    assign resume_go = cs_rise && opcode_r == fwp_pkg::OP_PE_RESUME &&
                     bitcnt_r == 12'(fwp_pkg::OPCODE_BITS) &&
                     depth_r != 2'h0 && !busy_r; // RULE_01
    assign done = busy_r && cnt_r == 16'h0001 && !suspend_go;

    // self-timed engine with a two-deep suspend stack
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            busy_r       <= 1'b0;
            job_r        <= fwp_pkg::JOB_STATUS;
            cnt_r        <= 16'h0000;
            depth_r      <= 2'h0;
            stk_cnt_r[0] <= 16'h0000;
            stk_cnt_r[1] <= 16'h0000;
            stk_job_r[0] <= fwp_pkg::JOB_STATUS;
            stk_job_r[1] <= fwp_pkg::JOB_STATUS;
        end
        else if (suspend_go)
        begin
            stk_cnt_r[depth_r[0]] <= cnt_r;
            stk_job_r[depth_r[0]] <= job_r;
            depth_r               <= depth_r + 2'h1;
            busy_r                <= 1'b0;
        end
        else if (status_write_cmd_go)
        begin
            busy_r <= 1'b1; // RULE_09
            job_r  <= fwp_pkg::JOB_STATUS;
            cnt_r  <= 16'(SR_CYCLES);
        end
        else if (prog_go)
        begin
            busy_r <= 1'b1;
            job_r  <= fwp_pkg::JOB_PROGRAM;
            cnt_r  <= 16'(PGM_CYCLES);
        end
        else if (erase_go || bulk_go)
        begin
            busy_r <= 1'b1;
            job_r  <= fwp_pkg::JOB_ERASE;
            cnt_r  <= 16'(ERS_CYCLES);
        end
        else if (resume_go)
        begin
            // last pushed job comes back first
            busy_r  <= 1'b1; // RULE_02 RULE_03
            job_r   <= stk_job_r[depth_r[1]];
            cnt_r   <= stk_cnt_r[depth_r[1]];
            depth_r <= depth_r - 2'h1;
        end
        else if (busy_r)
        begin
            cnt_r <= cnt_r - 16'h0001;
            if (done)
                busy_r <= 1'b0; // RULE_09
        end
    end

    // write enable latch: a set in the same cycle wins over a clear
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            wel_r <= 1'b0;
        else
        begin
            if (done || lock_write_cmd_go)
                wel_r <= 1'b0; // RULE_09 RULE_21
            if (write_enable_cmd_go)
                wel_r <= 1'b1; // RULE_06
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            sr_hi_r <= fwp_pkg::SR_HI_RESET;
        else if (status_write_cmd_go)
            sr_hi_r <= sh_r[7:2]; // RULE_08 RULE_10
    end

    // volatile sector locks; lock-down bits cleared only by reset, write-lock bits also by lock write
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            wlock_r <= {NUM_SECTORS{fwp_pkg::LK_RESET}};
            ldown_r <= {NUM_SECTORS{fwp_pkg::LK_RESET}};
        end
        else if (lock_write_cmd_go && !ldown_r[sec]) // RULE_19
        begin
            wlock_r[sec] <= sh_r[fwp_pkg::LK_WRITE_LOCK_BIT]; // RULE_18
            ldown_r[sec] <= sh_r[fwp_pkg::LK_DOWN_BIT] | ldown_r[sec];
        end
    end

    assign lock_byte = sec_ok ? {6'h00, ldown_r[sec], wlock_r[sec]}
                              : 8'h00; // RULE_18
    assign rd_sr = opcode_r == fwp_pkg::OP_STATUS_READ &&
                   bitcnt_r >= 12'(fwp_pkg::OPCODE_BITS); // RULE_04
    assign rd_lk = opcode_r == fwp_pkg::OP_LOCK_READ && !rd_reject_r &&
                   bitcnt_r >= 12'(fwp_pkg::OPCODE_BITS +
                                   fwp_pkg::ADDR_BITS); // RULE_15

    // serial output, msb first, driven from the falling clock
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst || lvl[0])
        begin
            spi.miso      <= 1'b1;
            spi.miso_oe_n <= 1'b1; // RULE_16
        end
        else if (sclk_fall && rd_sr)
        begin
            spi.miso      <= o_status[~bitcnt_r[2:0]]; // RULE_04
            spi.miso_oe_n <= 1'b0;
        end
        else if (sclk_fall && rd_lk)
        begin
            spi.miso      <= lock_byte[~bitcnt_r[2:0]];
            spi.miso_oe_n <= 1'b0;
        end
    end

    assign o_status        = {sr_hi_r, wel_r, busy_r}; // RULE_23
    assign o_pe_ready      = ~busy_r; // RULE_02
    assign o_suspend_depth = depth_r;
endmodule // fwp_flash_dev

// ### rtl/fwp_spi_host.sv
/*
 * host end of the link: runs one framed instruction per start request,
 * makes the serial clock by dividing the system clock, and returns the
 * last byte read.
 * assumes the flash answers within one half period of the serial clock.
 */
`timescale 1ns/1ns
module fwp_spi_host #(
    parameter int HALF = fwp_pkg::SCLK_HALF_CYCLES
) (
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    // command port
    input  wire logic        i_start,
    input  wire logic [7:0]  i_opcode,
    input  wire logic        i_addr_en,
    input  wire logic [23:0] i_addr,
    input  wire logic        i_wr_en,
    input  wire logic [7:0]  i_wr_byte,
    input  wire logic [1:0]  i_rd_bytes,
    input  wire logic        i_wp_n,
    output logic             o_busy,
    output logic             o_done,
    output logic [7:0]       o_rd_data,
    // serial link
    fwp_spi_if.host          spi
);
    // the flash needs about 8 system clocks to answer a falling edge
    if (HALF < 10 || HALF > 255)
        $error("HALF must lie in 10..255");

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_LOW   = 4'b0010,
        ST_HIGH  = 4'b0100,
        ST_TRAIL = 4'b1000
    } fwp_host_st_type;

    fwp_host_st_type st_r;
    logic [7:0]  half_r;
    logic [6:0]  bits_r;
    logic [39:0] tx_r;
    logic [7:0]  rx_r;
    logic        miso_lvl;
    logic        half_end;

    fwp_pin_sync #(
        .WIDTH (1),
        .INIT  (1'b1)
    ) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_pin     (spi.miso_line),
        .o_level   (miso_lvl),
        .o_rise    (),
        .o_fall    ()
    );

    assign half_end = half_r == 8'(HALF - 1);
    assign o_busy   = st_r != ST_IDLE;

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            spi.wp_n <= 1'b1;
        else
            spi.wp_n <= i_wp_n;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            st_r      <= ST_IDLE;
            half_r    <= 8'h00;
            bits_r    <= 7'h00;
            tx_r      <= 40'h00_0000_0000;
            rx_r      <= 8'h00;
            o_done    <= 1'b0;
            o_rd_data <= 8'h00;
            spi.cs_n  <= 1'b1;
            spi.sclk  <= 1'b0;
            spi.mosi  <= 1'b0;
        end
        else
        begin
            o_done <= 1'b0;
            half_r <= half_end ? 8'h00 : half_r + 8'h01;
            case (st_r)
                ST_IDLE:
                begin
                    half_r <= 8'h00;
                    if (i_start)
                    begin
                        st_r     <= ST_LOW;
                        spi.cs_n <= 1'b0;
                        spi.mosi <= i_opcode[7];
                        tx_r     <= i_addr_en ?
                                    {i_opcode, i_addr, i_wr_byte} :
                                    {i_opcode, i_wr_byte, 24'h00_0000};
                        bits_r   <= 7'd8 + (i_addr_en ? 7'd24 : 7'd0) +
                                    (i_wr_en ? 7'd8 : 7'd0) +
                                    {2'h0, i_rd_bytes, 3'h0};
                    end
                end
                ST_LOW:
                    if (half_end)
                    begin
                        st_r     <= ST_HIGH;
                        spi.sclk <= 1'b1;
                        rx_r     <= {rx_r[6:0], miso_lvl};
                    end
                ST_HIGH:
                    if (half_end)
                    begin
                        spi.sclk <= 1'b0;
                        bits_r   <= bits_r - 7'd1; // RULE_07 RULE_20
                        tx_r     <= {tx_r[38:0], 1'b0};
                        spi.mosi <= tx_r[38];
                        st_r     <= (bits_r == 7'd1) ? ST_TRAIL : ST_LOW;
                    end
                ST_TRAIL:
                    if (half_end)
                    begin
                        if (!spi.cs_n)
                            spi.cs_n <= 1'b1; // RULE_16
                        else
                        begin
                            st_r      <= ST_IDLE;
                            o_done    <= 1'b1;
                            o_rd_data <= rx_r;
                        end
                    end
                default:
                    st_r <= ST_IDLE;
            endcase
        end
    end
endmodule // fwp_spi_host

// ### sim/fwp_link_props.sv
/* link wire checks for the flash protection block.
   assumes it watches the interface joining both design ends. */
`timescale 1ns/1ns
module fwp_link_props (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // link wires
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe_n
);
    logic [5:0] bits_r;

    default clocking @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    // host frames reach 64 bits; six bits wrap at 64, which keeps the low three bits right
    always_ff @(posedge i_clk_sys)
        if (i_rst || cs_n)
            bits_r <= 6'h00;
        else if ($rose(sclk))
            bits_r <= bits_r + 6'h01;

    sequence s_gap;
        cs_n [*8];
    endsequence

    property p_bytes; $rose(cs_n) |-> bits_r[2:0] == 3'h0; endproperty
    a_bytes: assert property (p_bytes)
        else $error("frame not whole bytes");
    property p_gap; $rose(cs_n) |-> s_gap; endproperty
    a_gap: assert property (p_gap)
        else $error("deselect too short");
    property p_idle; cs_n |-> !sclk; endproperty
    a_idle: assert property (p_idle)
        else $error("clock high while deselected");
    property p_high; $rose(sclk) |-> sclk [*8]; endproperty
    a_high: assert property (p_high)
        else $error("clock high phase short");
    property p_mosi; sclk && $past(sclk) |-> $stable(mosi); endproperty
    a_mosi: assert property (p_mosi)
        else $error("input data moved while clock high");
    property p_miso;
        !miso_oe_n && sclk && $past(sclk) |-> $stable(miso);
    endproperty
    a_miso: assert property (p_miso)
        else $error("output data moved while clock high");
    property p_rel; $rose(cs_n) |-> ##[1:8] miso_oe_n; endproperty
    a_rel: assert property (p_rel)
        else $error("output not released");
    property p_quiet; s_gap |-> miso_oe_n; endproperty
    a_quiet: assert property (p_quiet)
        else $error("output driven while deselected");
endmodule // fwp_link_props

// ### sim/fwp_flash_write_protect_and_lock_regs_tb.sv
/* bench joining host and flash ends over the link.
   assumes a long status write cycle so reads overlap it. */
`timescale 1ns/1ns
module fwp_flash_write_protect_and_lock_regs_tb;
    logic        clk;
    logic        rst;
    logic        start;
    logic [7:0]  op;
    logic        aen;
    logic [23:0] addr;
    logic        wen;
    logic [7:0]  wb;
    logic [1:0]  rdn;
    logic        wp;
    logic        done;
    logic [7:0]  rd;
    logic [7:0]  status;
    logic        hwp;
    logic [1:0]  depth;
    logic        rdy;
    int          errors = 0;
    int          samples_checked = 0;

    fwp_spi_if link ();
    fwp_spi_host #(.HALF(10)) fwp_spi_host_inst (.i_clk_sys(clk),
        .i_rst(rst), .i_start(start), .i_opcode(op), .i_addr_en(aen),
        .i_addr(addr), .i_wr_en(wen), .i_wr_byte(wb), .i_rd_bytes(rdn),
        .i_wp_n(wp), .o_busy(), .o_done(done), .o_rd_data(rd), .spi(link));
    // long cycles outlast whole frames, so suspends and reads overlap
    fwp_flash_dev #(.SR_CYCLES(1500), .PGM_CYCLES(600), .ERS_CYCLES(2000))
        fwp_flash_dev_inst (.i_clk_sys(clk), .i_rst(rst), .spi(link),
        .o_status(status), .o_pe_ready(rdy), .o_hw_protected(hwp),
        .o_suspend_depth(depth));
    fwp_link_props fwp_link_props_inst (.i_clk_sys(clk), .i_rst(rst),
        .cs_n(link.cs_n), .sclk(link.sclk), .mosi(link.mosi),
        .miso(link.miso), .miso_oe_n(link.miso_oe_n));

    task automatic final_report;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] s);
        samples_checked++;
        if (s !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic cmd(input logic [7:0] o, input logic [1:0] f,
                       input logic [23:0] a, input logic [7:0] w,
                       input logic [1:0] r);
        @(posedge clk);
        {op, aen, wen, addr, wb, rdn} <= {o, f, a, w, r};
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (int n = 0; n < 2000; n++)
        begin
            @(negedge clk);
            if (done === 1'b1)
                return;
        end
        errors++;
        final_report();
    endtask

    task automatic op8(input logic [7:0] o);
        cmd(o, 2'b00, 24'h0, 8'h00, 2'd0);
    endtask

    task automatic write_enable_cmd;
        op8(fwp_pkg::OP_WRITE_ENABLE);
    endtask

    task automatic sw(input logic [7:0] d);
        cmd(fwp_pkg::OP_STATUS_WRITE, 2'b01, 24'h0, d, 2'd0);
    endtask

    task automatic lw(input logic [7:0] d);
        cmd(fwp_pkg::OP_LOCK_WRITE, 2'b11, 24'h05a000, d, 2'd0);
    endtask

    task automatic lr;
        cmd(fwp_pkg::OP_LOCK_READ, 2'b10, 24'h05ffff, 8'h00, 2'd1);
    endtask

    task automatic pin(input logic v);
        @(posedge clk);
        wp <= v;
    endtask

    task automatic idle;
        for (int n = 0; n < 10; n++)
        begin
            cmd(fwp_pkg::OP_STATUS_READ, 2'b00, 24'h0, 8'h00, 2'd1);
            if (rd[0] === 1'b0)
                return;
        end
        errors++;
        final_report();
    endtask

    task automatic t_status;
        write_enable_cmd();
        chk("latch", 8'h02, status);
        sw(8'h9d);
        chk("busy", 8'h9f, status);
        cmd(fwp_pkg::OP_STATUS_READ, 2'b00, 24'h0, 8'h00, 2'd3);
        chk("repeat", 8'h9f, rd);
        idle();
        chk("after", 8'h9c, status);
        $display("status write test done");
    endtask

    task automatic t_protect;
        pin(1'b0);
        write_enable_cmd();
        chk("hw mode", 8'h01, {7'h0, hwp});
        sw(8'h00);
        chk("refused", 8'h9c, status & 8'hfc);
        pin(1'b1);
        write_enable_cmd();
        chk("hw exit", 8'h00, {7'h0, hwp});
        sw(8'h20);
        idle();
        chk("accepted", 8'h20, status);
        pin(1'b0);
        write_enable_cmd();
        sw(8'h00);
        idle();
        chk("no disable", 8'h00, status);
        write_enable_cmd();
        cmd(fwp_pkg::OP_STATUS_WRITE, 2'b11, 24'h0, 8'h3c, 2'd0);
        chk("bad frame", 8'h02, status);
        pin(1'b1);
        $display("protection test done");
    endtask

    task automatic t_lock;
        lw(8'h01);
        chk("latch clear", 8'h00, status);
        lr();
        chk("write lock", 8'h01, rd);
        write_enable_cmd();
        lw(8'h03);
        write_enable_cmd();
        lw(8'h00);
        lr();
        chk("lock down", 8'h03, rd);
        write_enable_cmd();
        sw(8'h00);
        lw(8'h00);
        chk("busy lw", 8'h03, status);
        lr();
        chk("busy read", 8'hff, rd);
        idle();
        $display("lock test done");
    endtask

    task automatic t_resume;
        op8(fwp_pkg::OP_PE_RESUME);
        chk("depth", 8'h00, {6'h0, depth});
        chk("still idle", 8'h00, status);
        write_enable_cmd();
        cmd(fwp_pkg::OP_SECTOR_ERASE, 2'b10, 24'h100000, 8'h00, 2'd0);
        op8(fwp_pkg::OP_PE_SUSPEND);
        write_enable_cmd();
        cmd(fwp_pkg::OP_PAGE_PROGRAM, 2'b11, 24'h200000, 8'h5a, 2'd0);
        op8(fwp_pkg::OP_PE_SUSPEND);
        chk("nested", 8'h02, {6'h0, depth});
        op8(fwp_pkg::OP_PE_RESUME);
        chk("resumed", 8'h01, {6'h0, rdy, status[0]});
        repeat (3) op8(fwp_pkg::OP_STATUS_READ);
        chk("newest", 8'h01, {status[5:0], depth});
        op8(fwp_pkg::OP_PE_RESUME);
        chk("older", 8'h00, {5'h0, depth, rdy});
        $display("resume test done");
    endtask

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial
    begin
        rst = 1'b1;
        start = 1'b0;
        {op, aen, wen, addr, wb, rdn} = '0;
        wp = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_status();
        t_protect();
        t_lock();
        t_resume();
        final_report();
    end
endmodule // fwp_flash_write_protect_and_lock_regs_tb
